// ### ufs_supervisor.sv
// The address map and the strobed register port were decided locally.
`default_nettype none

module ufs_supervisor #(
  parameter int unsigned WARN_DEB_CYCLES = ufs_pkg::WARN_DEBOUNCE_CYC, // 20 ms warning filter
  parameter int unsigned BUS_DEB_CYCLES  = ufs_pkg::BUS_DEBOUNCE_CYC,  // 16 ms bus filter
  parameter int unsigned RETRY_UNIT      = ufs_pkg::RETRY_UNIT_CYC,    // retry step
  parameter int unsigned ILIM_UNIT       = ufs_pkg::ILIM_UNIT_CYC      // current limit step
) (
  input  wire logic                       i_clk,            // 100 MHz clock
  input  wire logic                       i_reset_n,        // async reset, active low
  input  wire logic [ufs_pkg::ADDR_W-1:0] i_addr,           // register address
  input  wire logic [ufs_pkg::DATA_W-1:0] i_wdata,          // register write data
  input  wire logic                       i_wr,             // write strobe
  input  wire logic                       i_rd,             // read strobe
  output logic      [ufs_pkg::DATA_W-1:0] o_rdata,          // read data, cycle after i_rd
  input  wire logic                       i_overtemp,       // die over shutdown limit
  input  wire logic                       i_overtemp_warn,  // die over warning limit
  input  wire logic                       i_supply_ov,      // input supply overvoltage
  input  wire logic                       i_dataline_ov,    // protected data lines overvoltage
  input  wire logic                       i_bus_oc,         // bus dc overcurrent
  input  wire logic                       i_sense_low,      // load sense below 4.38 V
  input  wire logic                       i_sense_short,    // load sense below 2 V
  input  wire logic                       i_sense_ov,       // load sense overvoltage
  input  wire logic                       i_switch_cycle,   // one pulse per converter cycle
  input  wire logic                       i_switch_node_oc, // switch node overcurrent
  input  wire logic                       i_fault_in,       // level seen on the fault pin
  output logic                            o_fault_out,      // fault pin drive value
  output logic                            o_fault_oe_n,     // low while pulling fault pin low
  output logic                            o_irq,            // interrupt, active high level
  output logic                            o_converter_en,   // converter allowed to run
  output logic                            o_data_switch_en, // data switches closed
  output logic                            o_host_pullup_en, // host pull-up enabled
  output logic                            o_charger_reset   // hold charger emulation in reset
);

  ufs_pkg::ufs_state_type state;       // all registered state
  ufs_pkg::ufs_state_type next_state;  // next value of the state

  // combinational helpers
  logic [8:0]                 raw;          // qualified conditions, slow ones taken after their filters
  logic [8:0]                 det;          // debounced, reportable conditions
  logic [3:0]                 deb_in;       // inputs of the four filters
  logic [3:0][ufs_pkg::CNT_W-1:0] deb_tgt;  // filter lengths
  logic [3:0]                 deb_done;     // filter reached its length
  logic [ufs_pkg::CNT_W-1:0]  ilim_cyc;     // extra current limit delay
  logic [ufs_pkg::CNT_W-1:0]  retry_tgt;    // retry delay in cycles
  logic [8:0]                 stop_evts;    // events that stop the converter
  logic [8:0]                 sd_evts;      // events that do not keep the retry loaded while they persist
  logic                       hold_retry;   // some condition keeps the retry loaded
  logic                       rd_event;     // event register read this cycle
  logic                       switch_short; // switch node overcurrent run complete
  logic [8:0]                 rise;         // newly seen conditions

  // current limit delay scales with its setting, zero at setting 0
  assign ilim_cyc  = ufs_pkg::CNT_W'(ILIM_UNIT * state.ilim_sel);
  // retry delay doubles per setting step
  assign retry_tgt = ufs_pkg::CNT_W'(RETRY_UNIT << state.retry_sel);

  // filter lengths, long ones are parameters so simulation can shorten them
  always_comb
  begin
    deb_tgt[ufs_pkg::DEB_WARN] = ufs_pkg::CNT_W'(WARN_DEB_CYCLES);
    deb_tgt[ufs_pkg::DEB_OC]   = ufs_pkg::CNT_W'(BUS_DEB_CYCLES) + ilim_cyc;
    deb_tgt[ufs_pkg::DEB_OCLV] = ufs_pkg::CNT_W'(BUS_DEB_CYCLES) + ilim_cyc;
    deb_tgt[ufs_pkg::DEB_UV]   = ufs_pkg::CNT_W'(BUS_DEB_CYCLES);
  end

  // inputs of the four slow filters
  assign deb_in[ufs_pkg::DEB_WARN] = i_overtemp_warn;
  assign deb_in[ufs_pkg::DEB_OC]   = i_bus_oc;
  assign deb_in[ufs_pkg::DEB_OCLV] = i_bus_oc & i_sense_low;
  assign deb_in[ufs_pkg::DEB_UV]   = i_sense_low;

  // a filter only reports once its input has stayed for the whole length
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      deb_done[k] = deb_in[k] && (state.deb_cnt[k] >= deb_tgt[k]);
    end
  end

  // four consecutive converter cycles with switch node overcurrent
  assign switch_short = (state.sw_run == ufs_pkg::SWITCH_OC_RUN);

  // condition vector; immediate ones pass straight through
  always_comb
  begin
    raw                         = '0;
    raw[ufs_pkg::EV_OT_SHD]     = i_overtemp;
    raw[ufs_pkg::EV_OT_WARN]    = deb_done[ufs_pkg::DEB_WARN];
    raw[ufs_pkg::EV_SUP_OV]     = i_supply_ov;
    raw[ufs_pkg::EV_DATALINE_OVERVOLT_FLAG]    = i_dataline_ov;
    raw[ufs_pkg::EV_BUS_OC]     = deb_done[ufs_pkg::DEB_OC];
    raw[ufs_pkg::EV_OC_LV]      = deb_done[ufs_pkg::DEB_OCLV];
    raw[ufs_pkg::EV_BUS_UV]     = deb_done[ufs_pkg::DEB_UV];
    raw[ufs_pkg::EV_GND_SHT]    = (i_bus_oc | switch_short) & i_sense_short;
    raw[ufs_pkg::EV_BUS_OV]     = i_sense_ov;
    det                         = raw;
  end

  // action groups that depend on the trip mode
  always_comb
  begin
    stop_evts = ufs_pkg::SWITCH_OPEN_EVTS;
    sd_evts   = '0;
    sd_evts[ufs_pkg::EV_GND_SHT] = 1'b1;
    if (!state.trip_mode)
    begin
      // mode 0: combined event shuts down; its retry waits for bus overcurrent and undervoltage to clear
      stop_evts[ufs_pkg::EV_OC_LV] = 1'b1;
      sd_evts[ufs_pkg::EV_OC_LV]   = 1'b1;
    end
    else
    begin
      // mode 1: combined event only reports, converter keeps running
      stop_evts[ufs_pkg::EV_OC_LV] = 1'b0;
    end
  end

  // retry stays loaded while a condition persists, except where the
  // retry is defined to start at shutdown; a new condition also reloads
  assign hold_retry = |(det & ~sd_evts) | |(det & ~state.act);

  assign rd_event = i_rd && (i_addr == ufs_pkg::OFS_EVENT);
  assign rise     = det & ~state.det_q;

  // next state
  always_comb
  begin
    next_state = state;

    // slow filters count while their input holds and restart when it drops
    for (int k = 0; k < 4; k++)
    begin
      if (!deb_in[k])
      begin
        next_state.deb_cnt[k] = '0;
      end
      else if (state.deb_cnt[k] < deb_tgt[k])
      begin
        next_state.deb_cnt[k] = state.deb_cnt[k] + 1'b1;
      end
    end

    // consecutive switch node overcurrent cycles, saturating at the run length
    if (i_switch_cycle)
    begin
      if (!i_switch_node_oc)
      begin
        next_state.sw_run = '0;
      end
      else if (state.sw_run != ufs_pkg::SWITCH_OC_RUN)
      begin
        next_state.sw_run = state.sw_run + 3'h1;
      end
    end

    next_state.det_q = det;

    // active faults latch and are released only after the retry delay
    if (hold_retry)
    begin
      next_state.retry_cnt = retry_tgt;
      next_state.act       = state.act | det;
    end
    else if (state.act != '0 && state.retry_cnt != '0)
    begin
      next_state.retry_cnt = state.retry_cnt - 1'b1;
      next_state.act       = state.act | det;
    end
    else
    begin
      // delay over: recover everything no longer detected
      next_state.act = det;
    end

    // event flags: a persisting condition comes back the cycle after the
    // read, so the interrupt visibly drops for one cycle; a new edge in
    // the read cycle wins over the clear and is not lost
    if (rd_event)
    begin
      next_state.flag = rise;
    end
    else
    begin
      next_state.flag = state.flag | det;
    end
    // auto clear: flag also drops once its fault is fully recovered
    if (state.auto_clear && !rd_event)
    begin
      next_state.flag = next_state.flag & (state.act | det);
    end

    // register writes
    if (i_wr)
    begin
      case (i_addr)
        ufs_pkg::OFS_CONTROL:
        begin
          next_state.retry_sel  = i_wdata[ufs_pkg::CTL_RETRY_LSB +: 2];
          next_state.trip_mode  = i_wdata[ufs_pkg::CTL_TRIP_BIT];
          next_state.auto_clear = i_wdata[ufs_pkg::CTL_AUTO_BIT];
          next_state.ilim_sel   = i_wdata[ufs_pkg::CTL_ILIM_LSB +: 2];
        end
        ufs_pkg::OFS_MASK:
        begin
          next_state.mask = i_wdata[ufs_pkg::NUM_EV-1:0];
        end
        default:
        begin
          // event and status are read only; unmapped writes are dropped
        end
      endcase
    end

    // register reads, answered in the following cycle only
    next_state.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        ufs_pkg::OFS_CONTROL:
        begin
          next_state.rdata[ufs_pkg::CTL_RETRY_LSB +: 2] = state.retry_sel;
          next_state.rdata[ufs_pkg::CTL_TRIP_BIT]       = state.trip_mode;
          next_state.rdata[ufs_pkg::CTL_AUTO_BIT]       = state.auto_clear;
          next_state.rdata[ufs_pkg::CTL_ILIM_LSB +: 2]  = state.ilim_sel;
        end
        ufs_pkg::OFS_MASK:
        begin
          next_state.rdata[ufs_pkg::NUM_EV-1:0] = state.mask;
        end
        ufs_pkg::OFS_EVENT:
        begin
          // value before the clear is returned
          next_state.rdata[ufs_pkg::NUM_EV-1:0] = state.flag;
        end
        ufs_pkg::OFS_STATUS:
        begin
          next_state.rdata[ufs_pkg::NUM_EV-1:0]  = state.act;
          next_state.rdata[ufs_pkg::STS_PIN_BIT]  = i_fault_in;
          next_state.rdata[ufs_pkg::STS_CONV_BIT] = ~|(state.act & stop_evts);
        end
        default:
        begin
          // unmapped address reads zero
          next_state.rdata = '0;
        end
      endcase
    end
  end

  // single state register; reset takes constants only
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state            <= '0;
      state.retry_sel  <= ufs_pkg::RST_RETRY_SEL;
      state.trip_mode  <= ufs_pkg::RST_TRIP_MODE;
      state.auto_clear <= ufs_pkg::RST_AUTO_CLEAR;
      state.ilim_sel   <= ufs_pkg::RST_ILIM_SEL;
      state.mask       <= ufs_pkg::RST_MASK;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs derive from registered state only
  assign o_rdata = state.rdata;

  // open drain: value always low, enable low while pulling; the mask
  // is not looked at here so software cannot hide a fault from the hub
  assign o_fault_out  = 1'b0;
  assign o_fault_oe_n = ~|(state.act & ufs_pkg::FAULT_PIN_EVENTS);

  // interrupt is a level of enabled flags only
  assign o_irq = |(state.flag & state.mask);

  // recovery actions are held off until the retry releases the event
  assign o_converter_en   = ~|(state.act & stop_evts);
  assign o_data_switch_en = ~|(state.act & ufs_pkg::SWITCH_OPEN_EVTS);
  assign o_host_pullup_en = ~state.act[ufs_pkg::EV_OT_SHD];
  assign o_charger_reset  = |(state.act & ufs_pkg::CHARGER_RST_EVTS);

endmodule

`default_nettype wire

// ### ufs_pkg.sv
`default_nettype none

package ufs_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ             = 100_000_000;
  localparam int unsigned CYCLES_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned WARN_DEBOUNCE_MS   = 20;
  localparam int unsigned WARN_DEBOUNCE_CYC  = WARN_DEBOUNCE_MS * CYCLES_PER_MS;
  localparam int unsigned BUS_DEBOUNCE_MS    = 16;
  localparam int unsigned BUS_DEBOUNCE_CYC   = BUS_DEBOUNCE_MS * CYCLES_PER_MS;
  localparam int unsigned RETRY_UNIT_MS      = 8;
  localparam int unsigned RETRY_UNIT_CYC     = RETRY_UNIT_MS * CYCLES_PER_MS;
  localparam int unsigned ILIM_UNIT_MS       = 2;
  localparam int unsigned ILIM_UNIT_CYC      = ILIM_UNIT_MS * CYCLES_PER_MS;
  localparam logic [2:0]  SWITCH_OC_RUN      = 3'h4;
  localparam int unsigned CNT_W              = 24;

  // register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_EVENT   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h3;

  // control and status register fields, reset values
  localparam int unsigned CTL_RETRY_LSB = 0;
  localparam int unsigned CTL_TRIP_BIT  = 2;
  localparam int unsigned CTL_AUTO_BIT  = 3;
  localparam int unsigned CTL_ILIM_LSB  = 4;
  localparam int unsigned STS_PIN_BIT   = 9;
  localparam int unsigned STS_CONV_BIT  = 10;
  localparam logic [1:0] RST_RETRY_SEL  = 2'h1;
  localparam logic       RST_TRIP_MODE  = 1'b0;
  localparam logic       RST_AUTO_CLEAR = 1'b1;
  localparam logic [1:0] RST_ILIM_SEL   = 2'h0;
  localparam logic [8:0] RST_MASK       = 9'h000;

  // event bit positions (same layout in flag, mask and status)
  localparam int unsigned NUM_EV     = 9;
  localparam int unsigned EV_OT_SHD  = 0;
  localparam int unsigned EV_OT_WARN = 1;
  localparam int unsigned EV_SUP_OV  = 2;
  localparam int unsigned EV_DATALINE_OVERVOLT_FLAG = 3;
  localparam int unsigned EV_BUS_OC  = 4;
  localparam int unsigned EV_OC_LV   = 5;
  localparam int unsigned EV_BUS_UV  = 6;
  localparam int unsigned EV_GND_SHT = 7;
  localparam int unsigned EV_BUS_OV  = 8;

  // action groups
  localparam logic [8:0] FAULT_PIN_EVENTS = 9'h1FD;
  localparam logic [8:0] SWITCH_OPEN_EVTS = 9'h18D;
  localparam logic [8:0] CHARGER_RST_EVTS = 9'h00C;

  // debounce counter slots
  localparam int unsigned DEB_WARN = 0;
  localparam int unsigned DEB_OC   = 1;
  localparam int unsigned DEB_OCLV = 2;
  localparam int unsigned DEB_UV   = 3;

  typedef struct packed {
    logic [1:0]             retry_sel;
    logic                   trip_mode;
    logic                   auto_clear;
    logic [1:0]             ilim_sel;
    logic [8:0]             mask;
    logic [8:0]             flag;
    logic [8:0]             det_q;
    logic [8:0]             act;
    logic [3:0][CNT_W-1:0]  deb_cnt;
    logic [2:0]             sw_run;
    logic [CNT_W-1:0]       retry_cnt;
    logic [DATA_W-1:0]      rdata;
  } ufs_state_type;

endpackage

`default_nettype wire

// ### ufs_host_model.sv
`default_nettype none

// hub side of the fault line: the controller only reads it through a pull-up
module ufs_host_model (
  input  wire logic i_pin_value, // value the supervisor drives when enabled
  input  wire logic i_pin_oe_n,  // low while the supervisor pulls the line
  output logic      o_pin_level  // level the controller and read-back see
);
  // released line floats up to the pull-up, never keeps the last driven value
  assign o_pin_level = i_pin_oe_n ? 1'b1 : i_pin_value;
endmodule

`default_nettype wire

// ### ufs_supervisor_checker.sv
`default_nettype none

module ufs_supervisor_checker #(
  parameter int unsigned RETRY_UNIT = 8 // retry step in cycles
) (
  input wire logic                       i_clk,            // clock
  input wire logic                       i_reset_n,        // async reset, active low
  input wire logic [ufs_pkg::ADDR_W-1:0] i_addr,           // register address
  input wire logic                       i_rd,             // read strobe
  input wire logic [ufs_pkg::DATA_W-1:0] o_rdata,          // read data
  input wire logic                       i_overtemp,       // shutdown condition
  input wire logic                       i_supply_ov,      // supply overvoltage
  input wire logic                       i_dataline_ov,    // data line overvoltage
  input wire logic                       i_bus_oc,         // bus overcurrent
  input wire logic                       i_sense_low,      // sense below low limit
  input wire logic                       i_sense_short,    // sense near ground
  input wire logic                       i_sense_ov,       // sense overvoltage
  input wire logic                       o_fault_oe_n,     // fault pin pulled when low
  input wire logic                       o_irq,            // interrupt
  input wire logic                       o_converter_en,   // converter running
  input wire logic                       o_data_switch_en, // switches closed
  input wire logic                       o_host_pullup_en, // pull-up on
  input wire logic                       o_charger_reset   // charger emulation held
);
  logic [15:0] ot_quiet; // cycles since overtemp last seen
  logic        imm;      // any undebounced cause except the ground short
  logic        any;      // any cause of the fault pin

  assign imm = i_overtemp | i_supply_ov | i_dataline_ov | i_sense_ov;
  assign any = imm | i_bus_oc | i_sense_low | i_sense_short;

  // saturating count, so a pull-up return can be held against the retry step
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ot_quiet <= 16'h0000;
    else if (i_overtemp)
      ot_quiet <= 16'h0000;
    else if (ot_quiet != 16'hFFFF)
      ot_quiet <= ot_quiet + 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_FAULT_WHILE_COND: assert property (imm |=> !o_fault_oe_n)
    else $error("fault pin released during an immediate fault");
  AST_OVERTEMP_ACTIONS: assert property (i_overtemp |=>
    !o_converter_en && !o_data_switch_en && !o_host_pullup_en)
    else $error("overtemp actions missing");
  AST_SUPPLY_ACTIONS: assert property ((i_supply_ov || i_dataline_ov) |=>
    o_charger_reset && !o_converter_en && !o_data_switch_en)
    else $error("supply overvoltage actions missing");
  AST_BUS_OV_ACTIONS: assert property (i_sense_ov |=>
    !o_fault_oe_n && !o_converter_en && !o_data_switch_en)
    else $error("bus overvoltage actions missing");
  AST_GROUND_SHORT: assert property ($rose(i_bus_oc && i_sense_short) |=>
    !o_fault_oe_n && !o_converter_en && !o_data_switch_en)
    else $error("ground short actions missing");
  AST_IRQ_READ_DROP: assert property (o_irq && i_rd && i_addr == ufs_pkg::OFS_EVENT
    && $stable(any) |=> !o_irq)
    else $error("interrupt kept through event read");
  AST_NO_SPURIOUS_FAULT: assert property ($fell(o_fault_oe_n) |-> $past(any))
    else $error("fault pin asserted without a pin cause");
  AST_CONV_STOP_CAUSE: assert property ($fell(o_converter_en) |->
    $past(imm || i_sense_short || (i_bus_oc && i_sense_low)))
    else $error("converter stopped without a stopping cause");
  AST_PULLUP_RETRY: assert property ($rose(o_host_pullup_en) |-> ot_quiet >= RETRY_UNIT)
    else $error("pull-up restored before retry delay");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read answer cycle");

  CV_IRQ: cover property ($rose(o_irq));
  CV_CONV_STOP_DEB: cover property ($fell(o_converter_en) && !$past(imm));
  CV_PULLUP_BACK: cover property ($rose(o_host_pullup_en));
endmodule

bind ufs_supervisor ufs_supervisor_checker #(.RETRY_UNIT(RETRY_UNIT)) u_checker (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_overtemp(i_overtemp), .i_supply_ov(i_supply_ov), .i_dataline_ov(i_dataline_ov),
  .i_bus_oc(i_bus_oc), .i_sense_low(i_sense_low), .i_sense_short(i_sense_short),
  .i_sense_ov(i_sense_ov), .o_fault_oe_n(o_fault_oe_n), .o_irq(o_irq),
  .o_converter_en(o_converter_en), .o_data_switch_en(o_data_switch_en),
  .o_host_pullup_en(o_host_pullup_en), .o_charger_reset(o_charger_reset));

`default_nettype wire

// ### test_usb_port_fault_supervisor.sv
`default_nettype none

module test_usb_port_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WD = 30;      // shortened warning filter
  localparam int BD = 20;      // shortened bus filter
  localparam int RU = 8;       // retry step
  localparam int IU = 4;       // current limit step
  localparam int RT = RU << 1; // retry span at the reset setting of one

  typedef struct {
    logic [7:0] cond; // ot, warn, sup, data, oc, low, short, sov
    int         lat;  // cycles until the flag raises the interrupt
    logic [8:0] flag; // event flags expected
    logic [4:0] outs; // fault_oe_n, conv, switch, pullup, charger_reset
    int         rec;  // least wait before all outputs recover
  } ufs_tb_row_type;

  logic        i_clk = 1'b0;       // bench clock
  logic        i_reset_n = 1'b0;   // held low at start
  logic [3:0]  i_addr = 4'h0;      // register address
  logic [15:0] i_wdata = 16'h0000; // write data
  logic        i_wr = 1'b0;        // write strobe
  logic        i_rd = 1'b0;        // read strobe
  logic [7:0]  cond = 8'h00;       // fault condition levels
  logic        sw_cycle = 1'b0;    // converter cycle pulse
  logic        sw_oc = 1'b0;       // switch node overcurrent
  logic [15:0] o_rdata;            // read data
  logic        fault_level;        // resolved fault line
  logic        o_fault_out;        // fault drive value
  logic        o_fault_oe_n;       // fault drive enable
  logic        o_irq;              // interrupt
  logic        o_converter_en;     // converter running
  logic        o_data_switch_en;   // switches closed
  logic        o_host_pullup_en;   // pull-up on
  logic        o_charger_reset;    // charger emulation held
  int          error_cnt = 0;      // mismatches
  int          num_checks = 0;     // comparisons made
  int          cycle_cnt = 0;      // hang guard
  wire logic   quiet = o_fault_oe_n & o_converter_en & o_data_switch_en & o_host_pullup_en
                       & !o_charger_reset; // every action withdrawn

  // normal cases: one row per event kind at the reset control setting
  ufs_tb_row_type rows [9] = '{
    '{8'h01, 1, 9'h001, 5'h00, RT},  // overtemp shutdown
    '{8'h02, WD, 9'h002, 5'h1E, 0},  // warning leaves the pin alone
    '{8'h04, 1, 9'h004, 5'h03, RT},  // supply overvoltage
    '{8'h08, 1, 9'h008, 5'h03, RT},  // data line overvoltage
    '{8'h10, BD, 9'h010, 5'h0E, RT}, // overcurrent keeps converter
    '{8'h20, BD, 9'h040, 5'h0E, RT}, // bus undervoltage
    '{8'h30, BD, 9'h070, 5'h06, 0},  // overcurrent with low bus, retry from release
    '{8'h50, 1, 9'h080, 5'h02, 0},   // ground short, retry from stop
    '{8'h80, 1, 9'h100, 5'h02, RT}   // bus overvoltage
  };

  ufs_supervisor #(.WARN_DEB_CYCLES(WD), .BUS_DEB_CYCLES(BD), .RETRY_UNIT(RU), .ILIM_UNIT(IU))
  DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_overtemp(cond[0]), .i_overtemp_warn(cond[1]),
    .i_supply_ov(cond[2]), .i_dataline_ov(cond[3]), .i_bus_oc(cond[4]),
    .i_sense_low(cond[5]), .i_sense_short(cond[6]), .i_sense_ov(cond[7]),
    .i_switch_cycle(sw_cycle), .i_switch_node_oc(sw_oc), .i_fault_in(fault_level),
    .o_fault_out(o_fault_out), .o_fault_oe_n(o_fault_oe_n), .o_irq(o_irq),
    .o_converter_en(o_converter_en), .o_data_switch_en(o_data_switch_en),
    .o_host_pullup_en(o_host_pullup_en), .o_charger_reset(o_charger_reset));

  ufs_host_model u_host (
    .i_pin_value(o_fault_out), .i_pin_oe_n(o_fault_oe_n), .o_pin_level(fault_level));

  // free-running clock, 10 ns period
  always #5 i_clk = !i_clk;

  function automatic logic [15:0] outs();
    return {11'h000, o_fault_oe_n, o_converter_en, o_data_switch_en, o_host_pullup_en,
            o_charger_reset};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("ERROR t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // single-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe edge
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  // bounded wait for the interrupt, or for every action to be withdrawn
  task automatic wait_for(input bit idle, output int n);
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while (n < 300 && (idle ? quiet !== 1'b1 : o_irq !== 1'b1));
  endtask

  task automatic run(input ufs_tb_row_type r);
    int n;
    @(posedge i_clk);
    cond <= r.cond;
    wait_for(1'b0, n);
    chk_rng(n, r.lat, r.lat + 3);
    @(posedge i_clk);
    #1 chk(outs(), {11'h000, r.outs});
    rdc(ufs_pkg::OFS_EVENT, {7'h00, r.flag});
    @(posedge i_clk);
    cond <= 8'h00;
    wait_for(1'b1, n);
    chk_rng(n, r.rec, RT + 4);
    // auto clear drops the reappeared flag once the retry is over
    repeat (RT + 4) @(posedge i_clk);
    rdc(ufs_pkg::OFS_EVENT, 16'h0000);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well above the several hundred cycles the tests need
  always @(posedge i_clk)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    int n;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1 chk(outs(), 16'h001E);
    rdc(ufs_pkg::OFS_CONTROL, 16'h0009);
    rdc(ufs_pkg::OFS_MASK, 16'h0000);
    rdc(ufs_pkg::OFS_STATUS, 16'h0600);
    wr(4'hF, 16'hFFFF);
    wr(ufs_pkg::OFS_EVENT, 16'hFFFF);
    rdc(4'hF, 16'h0000);
    rdc(ufs_pkg::OFS_EVENT, 16'h0000);
    wr(ufs_pkg::OFS_MASK, 16'h01FF);
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    // masked event still drives the pin; read drops and re-raises the interrupt
    wr(ufs_pkg::OFS_MASK, 16'h0001);
    cond <= 8'h04;
    repeat (3) @(posedge i_clk);
    #1 chk({15'h0000, o_irq}, 16'h0000);
    chk(outs(), 16'h0003);
    rdc(ufs_pkg::OFS_STATUS, 16'h0004);
    rdc(ufs_pkg::OFS_EVENT, 16'h0004);
    wr(ufs_pkg::OFS_MASK, 16'h0004);
    @(posedge i_clk);
    #1 chk({15'h0000, o_irq}, 16'h0001);
    rdc(ufs_pkg::OFS_EVENT, 16'h0004);
    chk({15'h0000, o_irq}, 16'h0000);
    @(posedge i_clk);
    #1 chk({15'h0000, o_irq}, 16'h0001);
    @(posedge i_clk);
    cond <= 8'h00;
    wait_for(1'b1, n);
    chk_rng(n, RT, RT + 4);
    $display("mask and interrupt test done");
    // overcurrent shorter than the filter must stay hidden
    wr(ufs_pkg::OFS_MASK, 16'h01FF);
    cond <= 8'h10;
    repeat (BD - 2) @(posedge i_clk);
    cond <= 8'h00;
    repeat (5) @(posedge i_clk);
    #1 chk(outs(), 16'h001E);
    rdc(ufs_pkg::OFS_EVENT, 16'h0000);
    $display("transient test done");
    // limit delay lengthens the filter; trip mode one keeps the converter
    wr(ufs_pkg::OFS_CONTROL, 16'h0019);
    run(ufs_tb_row_type'{8'h10, BD + IU, 9'h010, 5'h0E, RT});
    wr(ufs_pkg::OFS_CONTROL, 16'h000D);
    run(ufs_tb_row_type'{8'h30, BD, 9'h070, 5'h0E, RT});
    // without auto clear a recovered event keeps its flag until read
    wr(ufs_pkg::OFS_CONTROL, 16'h0001);
    cond <= 8'h04;
    wait_for(1'b0, n);
    cond <= 8'h00;
    wait_for(1'b1, n);
    repeat (RT + 4) @(posedge i_clk);
    rdc(ufs_pkg::OFS_EVENT, 16'h0004);
    wr(ufs_pkg::OFS_CONTROL, 16'h0009);
    $display("control setting test done");
    // three switch-node overcurrent cycles are not yet a short, the fourth is
    cond <= 8'h40;
    sw_oc <= 1'b1;
    repeat (6)
    begin
      @(posedge i_clk);
      sw_cycle <= !sw_cycle;
    end
    @(posedge i_clk);
    #1 chk(outs(), 16'h001E);
    @(posedge i_clk);
    sw_cycle <= 1'b1;
    @(posedge i_clk);
    sw_cycle <= 1'b0;
    wait_for(1'b0, n);
    chk_rng(n, 0, 3);
    @(posedge i_clk);
    #1 chk(outs(), 16'h0002);
    @(posedge i_clk);
    cond <= 8'h00;
    sw_oc <= 1'b0;
    wait_for(1'b1, n);
    chk_rng(n, 0, RT + 4);
    $display("switch node short test done");
    print_verdict();
  end
endmodule

`default_nettype wire
